// [hdl/rsie_defs.svh]
// register offsets, field positions, reset values and timing for the receive
// status and interrupt enable block; included by the irq logic and its bench
`ifndef RSIE_DEFS_SVH
`define RSIE_DEFS_SVH

// ----------------------------------------------------------------------------
// register byte offsets on apb
// ----------------------------------------------------------------------------
`define RSIE_OFS_RX_STATUS 8'h00
`define RSIE_OFS_TX_IRQ_EN 8'h04
`define RSIE_OFS_RX_IRQ_EN 8'h08
`define RSIE_OFS_RX_MODE 8'h0c
`define RSIE_OFS_DMA_BURST 8'h10

// ----------------------------------------------------------------------------
// receive status bit positions
// ----------------------------------------------------------------------------
`define RSIE_BIT_PKT_STORED 7
`define RSIE_BIT_READ_TMO 6
`define RSIE_BIT_DMA_DONE 5
`define RSIE_BIT_REMOTE 4
`define RSIE_BIT_RUNT 3
`define RSIE_BIT_ALIGN 2
`define RSIE_BIT_CRC 1
`define RSIE_BIT_OVERFLOW 0

// ----------------------------------------------------------------------------
// receive mode bits and stored header status positions
// ----------------------------------------------------------------------------
`define RSIE_BIT_KEEP_ERRORED 5
`define RSIE_BIT_KEEP_RUNT 3
`define RSIE_HDR_GOOD 5
`define RSIE_MODE_MASK 8'h28

// ----------------------------------------------------------------------------
// reset values, masks, runt minimum length and remote type value
// ----------------------------------------------------------------------------
`define RSIE_RST_BYTE 8'h00
`define RSIE_TX_EN_MASK 8'h8e
`define RSIE_RUNT_MIN_LEN 11'h03c
`define RSIE_REMOTE_TYPE 16'h0900

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RSIE_CLK_PERIOD_NS 50
`define RSIE_READ_TMO_NS 2400000
`define RSIE_READ_TMO_CYCLES (`RSIE_READ_TMO_NS / `RSIE_CLK_PERIOD_NS)

`endif

// [hdl/rsie_pkg.sv]
// types shared by the receive status and interrupt enable block
// assumes rsie_defs.svh is on the include path
`default_nettype none

package rsie_pkg;

  // one report per finished frame from the receive datapath
  typedef struct packed {
    logic done;
    logic [10:0] len;
    logic [15:0] lenType;
    logic alignErr;
    logic crcErr;
    logic bufFull;
  } rsie_frame_t;

  typedef enum logic [2:0] {
    RSIE_TMO_IDLE = 3'b001,
    RSIE_TMO_COUNT = 3'b010,
    RSIE_TMO_HOLD = 3'b100
  } rsie_tmo_e;

  typedef struct packed {
    rsie_tmo_e fsm;
    logic [15:0] cnt;
    logic expire;
  } rsie_tmo_state_t;

  typedef struct packed {
    logic [7:0] rxStat;
    logic [7:0] txIe;
    logic [7:0] rxIe;
    logic [7:0] rxMode;
    logic [7:0] dmaBurst;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic dmaReq;
    logic [7:0] hdrStatus;
    logic hdrStrobe;
    logic eopPrev;
  } rsie_top_state_t;

endpackage

`default_nettype wire

// [hdl/rsie_sync.sv]
// two flip-flop synchroniser for pins entering the ref_clk domain
// assumes a level input that stays put for at least two clock periods
`default_nettype none

module rsie_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // level in and out
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  // meta_q feeds only the second stage
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

`default_nettype wire

// [hdl/rsie_read_timeout.sv]
// watchdog on a host memory read strobe that gets no ready answer
// assumes strobe already synchronised and dataReady from the ref_clk domain
`default_nettype none

module rsie_read_timeout
  import rsie_pkg::*;
#(
  parameter int unsigned CYCLES = 48000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // strobe and buffer state
  input wire logic strobe,
  input wire logic dataReady,
  // one-cycle pulse on expiry
  output logic expire
);
  localparam logic [15:0] LAST = 16'(CYCLES - 1);

  rsie_tmo_state_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.expire = 1'b0;
    case (st_q.fsm)
      RSIE_TMO_IDLE: begin
        if (strobe && !dataReady) begin
          st_d.fsm = RSIE_TMO_COUNT;
          st_d.cnt = 16'h0001;
        end
      end
      RSIE_TMO_COUNT: begin
        if (!strobe || dataReady) begin
          st_d.fsm = RSIE_TMO_IDLE;
        end else if (st_q.cnt >= LAST) begin
          // one flag per strobe, then wait for the strobe to drop
          st_d.fsm = RSIE_TMO_HOLD;
          st_d.expire = 1'b1;
        end else begin
          st_d.cnt = st_q.cnt + 16'h0001;
        end
      end
      RSIE_TMO_HOLD: begin
        if (!strobe) begin
          st_d.fsm = RSIE_TMO_IDLE;
        end
      end
      default: st_d.fsm = RSIE_TMO_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '{fsm: RSIE_TMO_IDLE, cnt: 16'h0000, expire: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign expire = st_q.expire;
endmodule

`default_nettype wire

// [hdl/rsie_irq_logic.sv]
// receive status flags, interrupt enables and interrupt output, as an apb slave
// assumes frame reports and dma requests come from ref_clk logic; eop and the
// host memory read strobe are pins and get synchronised here
//
// Notes on behaviour
// - set packet-stored flag whenever a received frame is written to the buffer
// - set read-timeout flag when read strobe gets no ready within 2.4 ms
// - set dma-finished flag on eop; while set, never raise the dma request
// - dma-finished clears by writing one to it or zero to burst control
// - set remote-type flag when length/type equals 0900H, high byte first (the code sets it only for stored frames)
// - set runt flag for frames under 60 bytes, preamble and crc excluded
// - set alignment flag when frame ends with one to seven extra bits
// - set crc flag when the frame check sequence mismatches
// - set overflow flag when a frame is rejected because the buffer is full
// - with either keep bit set, copy runt, align, crc into header status (keep-runt alone still discards align or crc errored frames)
// - with both keep bits clear, discard every errored frame unstored
// - status writes clear only the bits written as ones; zeros leave them alone
// - clearing a flag withdraws its interrupt in the same write
// - each receive flag interrupts only while its enable bit is high
// - transmit enables exist only at bits 7, 3, 2 and 1
// - five flags describe the latest stored frame, updated on each store
`default_nettype none
`include "rsie_defs.svh"

module rsie_irq_logic #(
  parameter int unsigned READ_TMO_CYCLES = `RSIE_READ_TMO_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receive datapath
  input wire rsie_pkg::rsie_frame_t frame,
  input wire logic rdDataReady,
  output logic hdrStrobe,
  output logic [7:0] hdrStatus,
  // host pins
  input wire logic hostMemRdPin,
  input wire logic dmaEopPin,
  // dma engine and transmit section
  input wire logic dreqRaw,
  output logic dmaReq,
  input wire logic [7:0] txStatus,
  // interrupt to host
  output logic irq
);
  import rsie_pkg::*;

  // --------------------------------------------------------------------------
  // pin synchronisers and read watchdog
  // --------------------------------------------------------------------------
  logic memRdSync;
  logic eopSync;
  logic tmoExpire;

  rsie_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .din({hostMemRdPin, dmaEopPin}),
    .dout({memRdSync, eopSync})
  );

  rsie_read_timeout #(
    .CYCLES(READ_TMO_CYCLES)
  ) u_read_tmo (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .strobe(memRdSync),
    .dataReady(rdDataReady),
    .expire(tmoExpire)
  );

  // --------------------------------------------------------------------------
  // frame classification
  // --------------------------------------------------------------------------
  rsie_top_state_t st_q, st_d;
  logic isRunt;
  logic isRemote;
  logic anyErr;
  logic keepErrored;
  logic keepRunt;
  logic storeNow;
  logic eopRise;

  always_comb begin
    isRunt = frame.len < `RSIE_RUNT_MIN_LEN;
    isRemote = frame.lenType == `RSIE_REMOTE_TYPE;
    anyErr = isRunt | frame.alignErr | frame.crcErr;
    keepErrored = st_q.rxMode[`RSIE_BIT_KEEP_ERRORED];
    keepRunt = st_q.rxMode[`RSIE_BIT_KEEP_RUNT];
    // runt keeping only rescues frames that are otherwise clean
    storeNow = frame.done && !frame.bufFull &&
               (!anyErr || keepErrored ||
                (keepRunt && !frame.alignErr && !frame.crcErr));
    eopRise = eopSync && !st_q.eopPrev;
  end

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  logic setupPh;
  logic wrEn;
  logic addrHit;
  logic [7:0] rdByte;

  always_comb begin
    setupPh = psel && !penable;
    wrEn = psel && penable && pwrite && st_q.pready;
    addrHit = 1'b1;
    rdByte = 8'h00;
    if (paddr == `RSIE_OFS_RX_STATUS) begin
      rdByte = st_q.rxStat;
    end else if (paddr == `RSIE_OFS_TX_IRQ_EN) begin
      rdByte = st_q.txIe;
    end else if (paddr == `RSIE_OFS_RX_IRQ_EN) begin
      rdByte = st_q.rxIe;
    end else if (paddr == `RSIE_OFS_RX_MODE) begin
      rdByte = st_q.rxMode;
    end else if (paddr == `RSIE_OFS_DMA_BURST) begin
      rdByte = st_q.dmaBurst;
    end else begin
      addrHit = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  logic [7:0] statSet;
  logic [7:0] statClr;

  always_comb begin
    st_d = st_q;
    statSet = 8'h00;
    statClr = 8'h00;

    // no wait state: answer is prepared in setup, completes in first access
    st_d.pready = setupPh;
    st_d.pslverr = setupPh && !addrHit;
    st_d.prdata = setupPh ? {24'h000000, rdByte} : 32'h00000000;

    statSet[`RSIE_BIT_PKT_STORED] = storeNow;
    statSet[`RSIE_BIT_READ_TMO] = tmoExpire;
    statSet[`RSIE_BIT_DMA_DONE] = eopRise;
    statSet[`RSIE_BIT_REMOTE] = storeNow && isRemote;
    // error flags rise even on frames discarded for errors so error-only monitoring works
    statSet[`RSIE_BIT_RUNT] = frame.done && !frame.bufFull && isRunt;
    statSet[`RSIE_BIT_ALIGN] = frame.done && !frame.bufFull && frame.alignErr;
    statSet[`RSIE_BIT_CRC] = frame.done && !frame.bufFull && frame.crcErr;
    statSet[`RSIE_BIT_OVERFLOW] = frame.done && frame.bufFull;

    if (wrEn) begin
      if (paddr == `RSIE_OFS_RX_STATUS) begin
        statClr = pwdata[7:0];
      end else if (paddr == `RSIE_OFS_TX_IRQ_EN) begin
        st_d.txIe = pwdata[7:0] & `RSIE_TX_EN_MASK;
      end else if (paddr == `RSIE_OFS_RX_IRQ_EN) begin
        st_d.rxIe = pwdata[7:0];
      end else if (paddr == `RSIE_OFS_RX_MODE) begin
        st_d.rxMode = pwdata[7:0] & `RSIE_MODE_MASK;
      end else if (paddr == `RSIE_OFS_DMA_BURST) begin
        st_d.dmaBurst = pwdata[7:0];
        if (pwdata[7:0] == 8'h00) begin
          statClr[`RSIE_BIT_DMA_DONE] = 1'b1;
        end
      end
    end

    // a flag set in the clearing cycle survives
    st_d.rxStat = (st_q.rxStat & ~statClr) | statSet;

    // interrupt follows the new flags, so a clear drops it on the same edge
    st_d.irq = |(st_d.rxStat & st_d.rxIe) |
               |(txStatus & st_d.txIe & `RSIE_TX_EN_MASK);

    st_d.dmaReq = dreqRaw && !st_d.rxStat[`RSIE_BIT_DMA_DONE];

    st_d.hdrStrobe = storeNow;
    if (storeNow) begin
      st_d.hdrStatus = 8'h00;
      st_d.hdrStatus[`RSIE_HDR_GOOD] = !anyErr;
      st_d.hdrStatus[`RSIE_BIT_REMOTE] = isRemote;
      st_d.hdrStatus[`RSIE_BIT_RUNT] = isRunt;
      st_d.hdrStatus[`RSIE_BIT_ALIGN] = frame.alignErr;
      st_d.hdrStatus[`RSIE_BIT_CRC] = frame.crcErr;
    end

    st_d.eopPrev = eopSync;
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
      st_q.rxStat <= `RSIE_RST_BYTE;
      st_q.txIe <= `RSIE_RST_BYTE;
      st_q.rxIe <= `RSIE_RST_BYTE;
      st_q.rxMode <= `RSIE_RST_BYTE;
      st_q.dmaBurst <= `RSIE_RST_BYTE;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign irq = st_q.irq;
  assign dmaReq = st_q.dmaReq;
  assign hdrStatus = st_q.hdrStatus;
  assign hdrStrobe = st_q.hdrStrobe;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  logic wrStat;
  logic dmaBurstZero;
  assign wrStat = wrEn && paddr == `RSIE_OFS_RX_STATUS;
  assign dmaBurstZero = wrEn && paddr == `RSIE_OFS_DMA_BURST && pwdata[7:0] == 8'h00;

  chk_pkt_flag_set: assert property (
    storeNow |=> st_q.rxStat[7] && hdrStrobe)
    else $error("packet stored flag not set after store");

  chk_timeout_flag: assert property (
    tmoExpire |=> st_q.rxStat[6])
    else $error("read timeout flag not set");

  chk_dreq_blocked: assert property (
    dmaReq |-> !st_q.rxStat[5])
    else $error("dma request while dma finished flag set");

  chk_dma_burst_clear: assert property (
    dmaBurstZero && !eopRise |=> !st_q.rxStat[5])
    else $error("zero burst write did not clear dma flag");

  chk_remote_flag: assert property (
    storeNow && isRemote |=> st_q.rxStat[4] && hdrStatus[4])
    else $error("remote type frame not flagged");

  chk_runt_flag: assert property (
    frame.done && !frame.bufFull && frame.len < `RSIE_RUNT_MIN_LEN |=> st_q.rxStat[3])
    else $error("short frame not flagged");

  chk_crc_align: assert property (
    frame.done && !frame.bufFull && frame.crcErr && frame.alignErr
      |=> st_q.rxStat[2:1] == 2'b11)
    else $error("crc or alignment error not flagged");

  chk_overflow_flag: assert property (
    frame.done && frame.bufFull |=> st_q.rxStat[0] && !hdrStrobe)
    else $error("overflow not flagged or frame stored");

  chk_hdr_copy: assert property (
    storeNow |=> hdrStatus[3:1] == $past({isRunt, frame.alignErr, frame.crcErr}))
    else $error("header status does not match errors");

  chk_discard_err: assert property (
    frame.done && anyErr && st_q.rxMode == 8'h00 |=> !hdrStrobe)
    else $error("errored frame stored with keep bits clear");

  chk_w1c_keep: assert property (
    wrStat |=> ($past(st_q.rxStat) & ~$past(pwdata[7:0]) & ~st_q.rxStat) == 8'h00)
    else $error("status bit lost on zero write");

  chk_irq_follow: assert property (
    |(st_q.rxStat & st_q.rxIe) |-> irq)
    else $error("enabled flag without interrupt");

  chk_irq_source: assert property (
    irq |-> |(st_q.rxStat & st_q.rxIe) || $past(txStatus) != 8'h00)
    else $error("interrupt without enabled source");

  chk_tx_reserved: assert property (
    (st_q.txIe & ~8'h8e) == 8'h00)
    else $error("reserved transmit enable bit set");

  chk_align_flag: assert property (
    frame.done && !frame.bufFull && frame.alignErr |=> st_q.rxStat[2])
    else $error("alignment error not flagged");

  chk_dma_flag_set: assert property (
    eopRise |=> st_q.rxStat[5] && !dmaReq)
    else $error("eop did not set dma flag or block request");

  chk_dreq_follow: assert property (
    dreqRaw && !st_d.rxStat[`RSIE_BIT_DMA_DONE] |=> dmaReq)
    else $error("dma request lost while dma flag clear");

  chk_pkt_unstored: assert property (
    !storeNow && !st_q.rxStat[7] |=> !st_q.rxStat[7])
    else $error("packet flag set without a stored frame");

  chk_remote_unstored: assert property (
    !storeNow && !st_q.rxStat[4] |=> !st_q.rxStat[4])
    else $error("remote flag set without a stored frame");

  chk_no_soft_set: assert property (
    statSet == 8'h00 |=> (st_q.rxStat & ~$past(st_q.rxStat)) == 8'h00)
    else $error("status bit set without a device event");

  chk_clear_drops_irq: assert property (
    wrStat && statSet == 8'h00 && (st_q.rxStat & ~pwdata[7:0] & st_q.rxIe) == 8'h00 &&
      (txStatus & st_q.txIe) == 8'h00 |=> !irq)
    else $error("interrupt kept after its flag was cleared");

  chk_irq_exact: assert property (
    irq == (|(st_q.rxStat & st_q.rxIe) ||
            |($past(txStatus) & st_q.txIe & `RSIE_TX_EN_MASK)))
    else $error("interrupt does not match enabled flags");

  chk_hdr_good: assert property (
    storeNow |=> hdrStatus[5] == $past(!anyErr))
    else $error("header good bit wrong");

  cov_store_good: cover property (storeNow && !anyErr);
  cov_timeout: cover property (tmoExpire);
  cov_eop_block: cover property (eopRise ##1 dreqRaw && !dmaReq);
  cov_clear_irq: cover property (irq && wrStat ##1 !irq);
  cov_keep_runt: cover property (storeNow && isRunt);
endmodule

`default_nettype wire

// [testbench/rsie_host_model.sv]
// host side pin model: memory read strobe, dma end of process, dma request
// assumes the bench calls its tasks from ref_clk process context
`default_nettype none

module rsie_host_model (
  // clock
  input wire logic ref_clk,
  // host pins
  output logic hostMemRdPin,
  output logic dmaEopPin,
  output logic dreqRaw
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    hostMemRdPin = 1'b0;
    dmaEopPin = 1'b0;
    dreqRaw = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // pin actions
  // ---------------------------------------------------------------------------
  // eop held three edges so the two-stage sync cannot miss it
  task automatic end_of_process();
    @(posedge ref_clk);
    dmaEopPin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    dmaEopPin <= 1'b0;
  endtask

  // strobe always dropped before the next read
  task automatic mem_read(input int n);
    @(posedge ref_clk);
    hostMemRdPin <= 1'b1;
    repeat (n) @(posedge ref_clk);
    hostMemRdPin <= 1'b0;
  endtask

  task automatic set_dreq(input logic v);
    @(posedge ref_clk);
    dreqRaw <= v;
  endtask
endmodule

`default_nettype wire

// [testbench/rx_status_irq_enable_logic_bench.sv]
// self-checking bench for rsie_irq_logic over apb
// assumes rsie_defs.svh on the include path and the host pin model beside it
`default_nettype none
`include "rsie_defs.svh"

module rx_status_irq_enable_logic_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import rsie_pkg::*;

  localparam int unsigned TMO = 20;
  localparam logic [7:0] ST = `RSIE_OFS_RX_STATUS;
  localparam logic [7:0] TXE = `RSIE_OFS_TX_IRQ_EN;
  localparam logic [7:0] RXE = `RSIE_OFS_RX_IRQ_EN;
  localparam logic [7:0] MODE = `RSIE_OFS_RX_MODE;
  localparam logic [7:0] DMAB = `RSIE_OFS_DMA_BURST;

  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  rsie_frame_t frame = '0;
  logic rdDataReady = 1'b1;
  logic hdrStrobe;
  logic [7:0] hdrStatus;
  logic hostMemRdPin;
  logic dmaEopPin;
  logic dreqRaw;
  logic dmaReq;
  logic [7:0] txStatus = 8'h00;
  logic irq;
  logic [31:0] rdData;
  logic gotErr;
  logic gotStrobe;
  logic [7:0] gotHdr;
  int err_total = 0;
  int n_tests = 0;

  always #25 ref_clk = ~ref_clk;

  rsie_irq_logic #(.READ_TMO_CYCLES(TMO)) rsie_irq_logic_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame(frame), .rdDataReady(rdDataReady),
    .hdrStrobe(hdrStrobe), .hdrStatus(hdrStatus), .hostMemRdPin(hostMemRdPin),
    .dmaEopPin(dmaEopPin), .dreqRaw(dreqRaw), .dmaReq(dmaReq),
    .txStatus(txStatus), .irq(irq)
  );

  rsie_host_model rsie_host_model_i (
    .ref_clk(ref_clk), .hostMemRdPin(hostMemRdPin), .dmaEopPin(dmaEopPin),
    .dreqRaw(dreqRaw)
  );

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge; answer taken there
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) chk(1'b0, 1'b1);
    rdData = prdata;
    gotErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rdData, {24'h0, exp});
  endtask

  task automatic send(input logic [10:0] len, input logic [15:0] lt,
                      input logic al, input logic cr, input logic bf);
    @(posedge ref_clk);
    frame <= '{done: 1'b1, len: len, lenType: lt, alignErr: al, crcErr: cr, bufFull: bf};
    @(posedge ref_clk);
    frame.done <= 1'b0;
    @(posedge ref_clk);
    gotStrobe = hdrStrobe;
    gotHdr = hdrStatus;
  endtask

  // service: read status and write back exactly what was read
  task automatic service();
    apb(1'b0, ST, 8'h00);
    apb(1'b1, ST, rdData[7:0]);
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs();
    rd(ST, 8'h00);
    rd(TXE, 8'h00);
    rd(RXE, 8'h00);
    rd(MODE, 8'h00);
    rd(DMAB, 8'h00);
    chk(gotErr, 1'b0);
    apb(1'b1, TXE, 8'hff);
    rd(TXE, 8'h8e);
    apb(1'b1, 8'h14, 8'hff);
    chk(gotErr, 1'b1);
    rd(8'h14, 8'h00);
  endtask

  task automatic t_good_frame();
    send(11'd64, 16'h0900, 1'b0, 1'b0, 1'b0);
    chk({gotStrobe, gotHdr}, {1'b1, 8'h30});
    rd(ST, 8'h90);
    apb(1'b1, ST, 8'h00);
    rd(ST, 8'h90);
    apb(1'b1, ST, 8'h10);
    rd(ST, 8'h80);
    send(11'd64, 16'h0009, 1'b0, 1'b0, 1'b0);
    rd(ST, 8'h80);
    service();
    rd(ST, 8'h00);
  endtask

  task automatic t_errors();
    send(11'd59, 16'h0800, 1'b0, 1'b0, 1'b0);
    chk(gotStrobe, 1'b0);
    rd(ST, 8'h08);
    service();
    send(11'd60, 16'h0800, 1'b0, 1'b0, 1'b0);
    rd(ST, 8'h80);
    service();
    apb(1'b1, MODE, 8'h20);
    send(11'd64, 16'h0800, 1'b1, 1'b1, 1'b0);
    chk({gotStrobe, gotHdr}, {1'b1, 8'h06});
    rd(ST, 8'h86);
    service();
    apb(1'b1, MODE, 8'h08);
    send(11'd40, 16'h0800, 1'b0, 1'b0, 1'b0);
    chk({gotStrobe, gotHdr}, {1'b1, 8'h08});
    rd(ST, 8'h88);
    service();
    apb(1'b1, MODE, 8'h00);
    send(11'd64, 16'h0800, 1'b0, 1'b1, 1'b0);
    chk(gotStrobe, 1'b0);
    rd(ST, 8'h02);
    service();
    send(11'd64, 16'h0900, 1'b0, 1'b1, 1'b1);
    chk(gotStrobe, 1'b0);
    rd(ST, 8'h01);
  endtask

  // overflow flag is still set on entry
  task automatic t_irq();
    chk(irq, 1'b0);
    apb(1'b1, RXE, 8'hfe);
    @(posedge ref_clk);
    chk(irq, 1'b0);
    apb(1'b1, RXE, 8'h01);
    @(posedge ref_clk);
    chk(irq, 1'b1);
    apb(1'b1, ST, 8'h01);
    @(posedge ref_clk);
    chk(irq, 1'b0);
    txStatus <= 8'h71;
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    txStatus <= 8'h02;
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b1);
    txStatus <= 8'h00;
    apb(1'b1, RXE, 8'h00);
  endtask

  task automatic t_dma();
    rsie_host_model_i.set_dreq(1'b1);
    repeat (2) @(posedge ref_clk);
    chk(dmaReq, 1'b1);
    rsie_host_model_i.end_of_process();
    repeat (4) @(posedge ref_clk);
    chk(dmaReq, 1'b0);
    rd(ST, 8'h20);
    apb(1'b1, DMAB, 8'h00);
    rd(ST, 8'h00);
    chk(dmaReq, 1'b1);
    rsie_host_model_i.end_of_process();
    repeat (4) @(posedge ref_clk);
    apb(1'b1, ST, 8'h20);
    rd(ST, 8'h00);
    rsie_host_model_i.set_dreq(1'b0);
  endtask

  task automatic t_timeout();
    @(posedge ref_clk);
    rdDataReady <= 1'b0;
    rsie_host_model_i.mem_read(TMO - 10);
    repeat (4) @(posedge ref_clk);
    rd(ST, 8'h00);
    rsie_host_model_i.mem_read(TMO + 10);
    rd(ST, 8'h40);
    rdDataReady <= 1'b1;
    service();
  endtask

  // ---------------------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------------------
  task automatic tally_and_finish();
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_regs();
    t_good_frame();
    t_errors();
    t_irq();
    t_dma();
    t_timeout();
    tally_and_finish();
  end
endmodule

`default_nettype wire
